// >>> mic_regs.svh
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
// error codes reported on err_code_o, as 16-bit two's complement
`define MIC_ERR_NONE 16'h0000
`define MIC_ERR_EXEC 16'hff38
`define MIC_ERR_NOT_CONFIGURED 16'hff34
`define MIC_ERR_NOT_INITIATED 16'hff32
`define MIC_ERR_INIT_IGNORED 16'hff2b
// command opcodes on cmd_op_i
`define MIC_OP_NONE 4'h0
`define MIC_OP_INIT_IMM 4'h1
`define MIC_OP_CONT_SET 4'h2
`define MIC_OP_CONT_QUERY 4'h3
`define MIC_OP_ABORT 4'h4
`define MIC_OP_MEASURE 4'h5
`define MIC_OP_CONFIGURE 4'h6
`define MIC_OP_FETCH 4'h7
`define MIC_OP_INIT_QUERY 4'h8
// reset values
`define MIC_CONT_RST 1'b0
`define MIC_INPUT_RST 2'h0
`endif

// >>> mic_pkg.sv
package mic_pkg;
  typedef enum logic [1:0] {
    MIC_IDLE,
    MIC_MEASURING
  } mic_state_e;
  typedef logic [31:0] mic_result_t;
endpackage : mic_pkg

// >>> mic_result_store.sv
`timescale 1ns/1ps
`include "mic_regs.svh"
// holds the most recent completed result; a newer one always overwrites it
module mic_result_store (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic done_i,
  input wire mic_pkg::mic_result_t data_i,
  input wire logic stale_i,
  output mic_pkg::mic_result_t result_o,
  output logic valid_o
);
  mic_pkg::mic_result_t result_d;
  mic_pkg::mic_result_t result_q;
  logic valid_d;
  logic valid_q;

  // a completed cycle replaces the old result; a config change makes it stale
  always_comb begin
    result_d = result_q;
    valid_d = valid_q;
    if (stale_i) begin
      valid_d = 1'b0;
    end
    if (done_i) begin
      result_d = data_i;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= '0;
      valid_q <= 1'b0;
    end else begin
      result_q <= result_d;
      valid_q <= valid_d;
    end
  end

  assign result_o = result_q;
  assign valid_o = valid_q;
endmodule : mic_result_store

// >>> mic_initiate_ctrl.sv
`timescale 1ns/1ps
`include "mic_regs.svh"
// Function
// - one-shot initiate leaves idle, runs exactly one cycle, returns idle.
// - one-shot initiate is an event; its query form is refused.
// - a configuration change during measurement aborts it.
// - initiate while busy or continuous is ignored, error -213.
// - continuous mode runs back-to-back cycles while arming is satisfied.
// - continuous off lets current cycle finish, then idle.
// - abort keeps continuous setting, ends cycle, continuous measuring restarts.
// - configuring another input in continuous mode gives -200, state unchanged.
// - reconfiguring the same input in continuous mode aborts, applies, resumes.
// - measure query clears continuous mode, then measures.
// - continuous query answers 1 when on, 0 when off.
// - initiate on an unconfigured input gives error -204.
// - each completed result replaces the stored result.
// - fetch without initiate gives -206 unless continuous is on.
module mic_initiate_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_op_i,
  input wire logic [1:0] cmd_input_i,
  input wire logic cmd_arg_i,
  input wire logic arm_ok_i,
  input wire logic meas_done_i,
  input wire mic_pkg::mic_result_t meas_data_i,
  output logic meas_start_o,
  output logic meas_abort_o,
  output logic [1:0] meas_input_o,
  output logic cfg_apply_o,
  output logic busy_o,
  output logic cont_o,
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o,
  output logic err_valid_o,
  output logic [15:0] err_code_o
);
  mic_pkg::mic_state_e state_d;
  mic_pkg::mic_state_e state_q;
  logic cont_d;
  logic cont_q;
  logic [1:0] input_d;
  logic [1:0] input_q;
  logic initiated_d;
  logic initiated_q;
  logic pend_d;
  logic pend_q;
  logic start_d;
  logic start_q;
  logic abort_d;
  logic abort_q;
  logic apply_d;
  logic apply_q;
  logic rsp_v_d;
  logic rsp_v_q;
  logic [31:0] rsp_d;
  logic [31:0] rsp_q;
  logic err_v_d;
  logic err_v_q;
  logic [15:0] err_d;
  logic [15:0] err_q;
  mic_pkg::mic_result_t store_q;
  logic store_valid;
  logic done;
  logic stale;
  // decode terms for the control and answer groups; mid_cycle is read by the control group only
  logic in_known;
  logic in_match;
  logic mid_cycle;
  logic init_busy;
  logic other_input;

  // a done pulse only counts while a cycle runs, so a late engine echo is ignored
  assign done = (state_q == mic_pkg::MIC_MEASURING) && meas_done_i;

  // both groups below read these except mid_cycle, so accept and refuse can never disagree
  assign in_known = input_q != `MIC_INPUT_RST;
  assign in_match = in_known && (cmd_input_i == input_q);
  assign mid_cycle = (state_q == mic_pkg::MIC_MEASURING) && !done;
  assign init_busy = (state_q != mic_pkg::MIC_IDLE) || cont_q;
  assign other_input = cont_q && in_known && (cmd_input_i != input_q);

  // command decode and measurement sequencing
  always_comb begin
    state_d = state_q;
    cont_d = cont_q;
    input_d = input_q;
    initiated_d = initiated_q;
    pend_d = pend_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    apply_d = 1'b0;
    stale = 1'b0;
    // a finished cycle returns to idle; continuous mode re-arms below
    if (done) begin
      state_d = mic_pkg::MIC_IDLE;
    end
    if (cmd_valid_i) begin
      case (cmd_op_i)
        // one-shot only from idle with continuous off, on the configured input
        `MIC_OP_INIT_IMM: begin
          if (!init_busy && in_match) begin
            pend_d = 1'b1;
            initiated_d = 1'b1;
          end
        end
        // continuous on needs a configured input; off lets the cycle run out
        `MIC_OP_CONT_SET: begin
          if (!cmd_arg_i || in_known) begin
            cont_d = cmd_arg_i;
            if (cmd_arg_i) begin
              initiated_d = 1'b1;
            end
          end
        end
        // continuous flag is left alone so the loop restarts
        `MIC_OP_ABORT: begin
          if (mid_cycle) begin
            abort_d = 1'b1;
            state_d = mic_pkg::MIC_IDLE;
          end
          pend_d = 1'b0;
        end
        // measure drops continuous mode and runs one fresh cycle
        `MIC_OP_MEASURE: begin
          if (in_match) begin
            cont_d = 1'b0;
            if (mid_cycle) begin
              abort_d = 1'b1;
              state_d = mic_pkg::MIC_IDLE;
            end
            pend_d = 1'b1;
            initiated_d = 1'b1;
          end
        end
        // a new setup cuts the running cycle and makes the old result stale
        `MIC_OP_CONFIGURE: begin
          if (!other_input) begin
            input_d = cmd_input_i;
            apply_d = 1'b1;
            stale = 1'b1;
            if (!cont_q) begin
              initiated_d = 1'b0;
              pend_d = 1'b0;
            end
            if (mid_cycle) begin
              abort_d = 1'b1;
              state_d = mic_pkg::MIC_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // launch when idle and a one-shot is pending or the continuous loop runs
    case (state_d)
      mic_pkg::MIC_IDLE: begin
        if ((pend_d || cont_d) && arm_ok_i && !abort_d && !apply_d) begin
          state_d = mic_pkg::MIC_MEASURING;
          start_d = 1'b1;
          pend_d = 1'b0;
        end
      end
      // stays until done, abort, measure or a configuration change
      mic_pkg::MIC_MEASURING: begin
      end
      default: begin
        state_d = mic_pkg::MIC_IDLE;
      end
    endcase
  end

  // answers and error codes; strobes stand one cycle, the words hold
  always_comb begin
    rsp_v_d = 1'b0;
    rsp_d = rsp_q;
    err_v_d = 1'b0;
    err_d = err_q;
    if (cmd_valid_i) begin
      case (cmd_op_i)
        `MIC_OP_INIT_IMM: begin
          if (init_busy) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_INIT_IGNORED;
          end else if (!in_match) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_NOT_CONFIGURED;
          end
        end
        // the one-shot keeps no state, so its query form is refused
        `MIC_OP_INIT_QUERY: begin
          err_v_d = 1'b1;
          err_d = `MIC_ERR_EXEC;
        end
        // continuous on with nothing configured keeps the flag off
        `MIC_OP_CONT_SET: begin
          if (cmd_arg_i && !in_known) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_NOT_CONFIGURED;
          end
        end
        `MIC_OP_CONT_QUERY: begin
          rsp_v_d = 1'b1;
          rsp_d = {31'h0, cont_q};
        end
        // a wrong input is refused before the loop is touched
        `MIC_OP_MEASURE: begin
          if (!in_match) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_NOT_CONFIGURED;
          end
        end
        `MIC_OP_CONFIGURE: begin
          if (other_input) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_EXEC;
          end
        end
        // nothing usable yet; report stale data as an execution error
        `MIC_OP_FETCH: begin
          if (!in_match) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_NOT_CONFIGURED;
          end else if (!initiated_q && !cont_q) begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_NOT_INITIATED;
          end else if (store_valid) begin
            rsp_v_d = 1'b1;
            rsp_d = store_q;
          end else begin
            err_v_d = 1'b1;
            err_d = `MIC_ERR_EXEC;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // control registers only; all decisions are made above
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= mic_pkg::MIC_IDLE;
      cont_q <= `MIC_CONT_RST;
      input_q <= `MIC_INPUT_RST;
      initiated_q <= 1'b0;
      pend_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      apply_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cont_q <= cont_d;
      input_q <= input_d;
      initiated_q <= initiated_d;
      pend_q <= pend_d;
      start_q <= start_d;
      abort_q <= abort_d;
      apply_q <= apply_d;
    end
  end

  // answer registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_v_q <= 1'b0;
      rsp_q <= '0;
      err_v_q <= 1'b0;
      err_q <= `MIC_ERR_NONE;
    end else begin
      rsp_v_q <= rsp_v_d;
      rsp_q <= rsp_d;
      err_v_q <= err_v_d;
      err_q <= err_d;
    end
  end

  // result memory, marked stale (result kept, valid cleared) on configuration changes
  mic_result_store u_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .done_i(done),
    .data_i(meas_data_i),
    .stale_i(stale),
    .result_o(store_q),
    .valid_o(store_valid)
  );

  // outputs straight from registers; busy decodes the state register
  assign meas_start_o = start_q;
  assign meas_abort_o = abort_q;
  assign meas_input_o = input_q;
  assign cfg_apply_o = apply_q;
  assign busy_o = (state_q == mic_pkg::MIC_MEASURING);
  assign cont_o = cont_q;
  assign rsp_valid_o = rsp_v_q;
  assign rsp_data_o = rsp_q;
  assign err_valid_o = err_v_q;
  assign err_code_o = err_q;
endmodule : mic_initiate_ctrl

// >>> mic_checker.sv
`timescale 1ns/1ps
`include "mic_regs.svh"
// command-to-answer relations seen at the top ports only
module mic_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_op_i,
  input wire logic [1:0] cmd_input_i,
  input wire logic cmd_arg_i,
  input wire logic arm_ok_i,
  input wire logic meas_done_i,
  input wire logic meas_start_o,
  input wire logic meas_abort_o,
  input wire logic [1:0] meas_input_o,
  input wire logic busy_o,
  input wire logic cont_o,
  input wire logic rsp_valid_o,
  input wire logic [31:0] rsp_data_o,
  input wire logic err_valid_o,
  input wire logic [15:0] err_code_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [3:0] op;
  logic ok;
  // idle cycles read as no-op, so antecedents need no strobe term
  assign op = cmd_valid_i ? cmd_op_i : `MIC_OP_NONE;
  assign ok = cmd_input_i != 2'h0 && cmd_input_i == meas_input_o;
  start_now_a: assert property (op == `MIC_OP_INIT_IMM && ok && !busy_o && !cont_o
    && arm_ok_i |=> meas_start_o && busy_o) else $error("no start");
  init_busy_a: assert property (op == `MIC_OP_INIT_IMM && (busy_o || cont_o)
    |=> err_valid_o && err_code_o == 16'hff2b) else $error("init not ignored");
  no_query_a: assert property (op == `MIC_OP_INIT_QUERY
    |=> err_valid_o && !rsp_valid_o) else $error("init query answered");
  cont_read_a: assert property (op == `MIC_OP_CONT_QUERY
    |=> rsp_valid_o && rsp_data_o == {31'h0, $past(cont_o)}) else $error("cont query");
  meas_clear_a: assert property (op == `MIC_OP_MEASURE && ok
    |=> !cont_o) else $error("measure kept cont");
  abort_keep_a: assert property (op == `MIC_OP_ABORT
    |=> $stable(cont_o)) else $error("abort changed cont");
  other_in_a: assert property (op == `MIC_OP_CONFIGURE && cont_o && !ok
    && meas_input_o != 2'h0 |=> err_code_o == 16'hff38 && cont_o) else $error("other input");
  unconf_init_a: assert property (op == `MIC_OP_INIT_IMM && !ok && !busy_o && !cont_o
    |=> err_code_o == 16'hff34 && !meas_start_o) else $error("unconfigured init");
  cfg_abort_a: assert property (op == `MIC_OP_CONFIGURE && busy_o && !meas_done_i
    && (!cont_o || ok) |=> meas_abort_o && !busy_o) else $error("config kept cycle");
  cont_off_a: assert property (op == `MIC_OP_CONT_SET && !cmd_arg_i
    && busy_o && !meas_done_i |=> busy_o && !cont_o && !meas_abort_o) else $error("cont off cut");
  arm_hold_a: assert property (!arm_ok_i
    |=> !meas_start_o) else $error("start without arm");
endmodule : mic_checker
bind mic_initiate_ctrl mic_checker i_chk (.*);

// >>> mic_engine_model.sv
`timescale 1ns/1ps
// engine stand-in; long latency so commands land mid-cycle
module mic_engine_model #(
  parameter int LAT = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic done_o,
  output logic [31:0] data_o
);
  int cnt;
  logic [31:0] res;
  // abort drops the cycle; data is inverted outside the done pulse
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      res <= 32'h00001000;
    end else if (abort_i) begin
      cnt <= 0;
    end else if (start_i) begin
      cnt <= LAT;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) res <= res + 32'h1;
    end
  end
  assign done_o = cnt == 1;
  assign data_o = done_o ? res : ~res;
endmodule : mic_engine_model

// >>> measurement_initiate_control_tb.sv
`timescale 1ns/1ps
`include "mic_regs.svh"
module measurement_initiate_control_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [3:0] cmd_op_i = 4'h0;
  logic [1:0] cmd_input_i = 2'h0;
  logic cmd_arg_i = 1'b0;
  logic arm_ok_i = 1'b1;
  logic meas_done_i, meas_start_o, meas_abort_o, cfg_apply_o, busy_o, cont_o;
  logic rsp_valid_o, err_valid_o;
  mic_pkg::mic_result_t meas_data_i, last;
  logic [1:0] meas_input_o;
  logic [31:0] rsp_data_o;
  logic [15:0] err_code_o;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  mic_initiate_ctrl i_dut (.*);
  mic_engine_model i_eng (.core_clk_i, .rst_n_i, .start_i(meas_start_o),
    .abort_i(meas_abort_o), .done_o(meas_done_i), .data_o(meas_data_i));
  initial forever #10 core_clk_i = ~core_clk_i;
  // keep the last finished result; cut a hang short
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (meas_done_i && busy_o) last <= meas_data_i;
    if (cyc == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // one command cycle; answers are visible when this returns
  task automatic cmd(input logic [3:0] op, input logic [1:0] in, input logic a);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_input_i = in;
    cmd_arg_i = a;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
  endtask : cmd
  task automatic idle_wait(input int n);
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
    repeat (n) @(negedge core_clk_i);
  endtask : idle_wait
  task automatic t_single();
    cmd(`MIC_OP_CONFIGURE, 2'h1, 1'b0);
    check({cfg_apply_o, meas_input_o}, 3'b101);
    cmd(`MIC_OP_FETCH, 2'h1, 1'b0);
    check({err_valid_o, err_code_o}, {1'b1, `MIC_ERR_NOT_INITIATED});
    cmd(`MIC_OP_INIT_IMM, 2'h2, 1'b0);
    check(err_code_o, `MIC_ERR_NOT_CONFIGURED);
    cmd(`MIC_OP_INIT_QUERY, 2'h1, 1'b0);
    check({rsp_valid_o, err_valid_o}, 2'b01);
    cmd(`MIC_OP_INIT_IMM, 2'h1, 1'b0);
    check({meas_start_o, busy_o}, 2'b11);
    cmd(`MIC_OP_INIT_IMM, 2'h1, 1'b0);
    check({err_valid_o, err_code_o}, {1'b1, `MIC_ERR_INIT_IGNORED});
    idle_wait(4);
    check(busy_o, 1'b0);
    cmd(`MIC_OP_FETCH, 2'h1, 1'b0);
    check({rsp_valid_o, rsp_data_o}, {1'b1, last});
  endtask : t_single
  task automatic t_cont();
    cmd(`MIC_OP_CONT_SET, 2'h1, 1'b1);
    check({cont_o, meas_start_o}, 2'b11);
    cmd(`MIC_OP_CONT_QUERY, 2'h1, 1'b0);
    check({rsp_valid_o, rsp_data_o}, {1'b1, 32'h1});
    cmd(`MIC_OP_CONFIGURE, 2'h2, 1'b0);
    check({err_code_o, cont_o, busy_o, meas_input_o}, {`MIC_ERR_EXEC, 4'b1101});
    cmd(`MIC_OP_CONFIGURE, 2'h1, 1'b0);
    check({cfg_apply_o, meas_abort_o}, 2'b11);
    idle_wait(3);
    check(busy_o, 1'b1);
    cmd(`MIC_OP_ABORT, 2'h1, 1'b0);
    check({meas_abort_o, cont_o}, 2'b11);
    repeat (3) @(negedge core_clk_i);
    check(busy_o, 1'b1);
    cmd(`MIC_OP_CONT_SET, 2'h1, 1'b0);
    check({cont_o, busy_o}, 2'b01);
    idle_wait(4);
    check(busy_o, 1'b0);
    cmd(`MIC_OP_CONT_SET, 2'h1, 1'b1);
    cmd(`MIC_OP_MEASURE, 2'h1, 1'b0);
    check(cont_o, 1'b0);
    repeat (3) @(negedge core_clk_i);
    check(busy_o, 1'b1);
    idle_wait(4);
    check(busy_o, 1'b0);
    // arming withheld: continuous on must wait for it
    arm_ok_i = 1'b0;
    cmd(`MIC_OP_CONT_SET, 2'h1, 1'b1);
    check({cont_o, meas_start_o, busy_o}, 3'b100);
    repeat (3) @(negedge core_clk_i);
    check(busy_o, 1'b0);
    arm_ok_i = 1'b1;
    @(negedge core_clk_i);
    check({meas_start_o, busy_o}, 2'b11);
    cmd(`MIC_OP_CONT_SET, 2'h1, 1'b0);
    idle_wait(4);
    cmd(`MIC_OP_FETCH, 2'h1, 1'b0);
    check({rsp_valid_o, rsp_data_o}, {1'b1, last});
  endtask : t_cont
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // reset for two cycles, then the scenarios in order
  initial begin
    repeat (2) @(negedge core_clk_i);
    check({busy_o, cont_o, meas_input_o, rsp_valid_o, err_valid_o}, 6'h0);
    rst_n_i = 1'b1;
    t_single();
    t_cont();
    stop_test();
  end
endmodule : measurement_initiate_control_tb
